/* sim/test_tmst_status.sv */
// Bench for the channel 3 to 5 event status flags.
`timescale 1ns/1ps
module test_tmst_status;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = '0;
   logic [15:0] wr_data = '0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] rd_data;
   logic [2:0]  cnt = '0;
   logic [5:0]  cap = '0;
   logic [15:0] event_status;
   int          errors = 0;
   int          check_count = 0;
   tmst_status i_tmst_status (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .count3_en(cnt[0]), .count4_en(cnt[1]), .count5_en(cnt[2]), .capture5a(cap[5]),
      .capture5b(cap[4]), .capture4a(cap[3]), .capture4b(cap[2]), .capture4c(cap[1]),
      .capture4d(cap[0]), .event_status);
   initial forever #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask
   task automatic drive(input logic [5:0] c, input logic [2:0] e, input int n);
      @(posedge sys_clk);
      cap <= c;
      cnt <= e;
      repeat (n) @(posedge sys_clk);
      cap <= '0;
      cnt <= '0;
   endtask
   // A read arms the flags, the zero write clears them, a last read proves it.
   task automatic clr(input logic [15:0] exp);
      rd(4'h0, exp);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      chk(event_status, 16'h0000);
      rd(4'h0, 16'h0000);
      wr(4'h3, 16'h1234);
      drive(6'h3F, 3'h0, 1);
      rd(4'h7, 16'h1234);
      rd(4'hA, 16'h1234);
      rd(4'hF, 16'h0000);
      rd(4'h0, 16'h0DE0);
      wr(4'h0, 16'hFFFF);
      wr(4'h0, 16'h0000);
      clr(16'h0DE0);
      wr(4'h2, 16'hFFFF);
      wr(4'h3, 16'hFFFF);
      drive(6'h00, 3'h3, 2);
      clr(16'h0210);
      rd(4'h2, 16'h0001);
      for (int i = 5; i <= 10; i++)
         wr(4'(i), 16'h0002);
      wr(4'h1, 16'h0555);
      drive(6'h00, 3'h6, 4);
      clr(16'h0DE0);
      for (int m = 0; m < 2; m++) begin
         wr(4'h1, (m == 0) ? 16'h0EAA : 16'h0FFF);
         wr(4'h3, 16'h0000);
         wr(4'h4, 16'h0000);
         drive(6'h3F, 3'h6, 4);
         clr(16'h0100);
      end
      wr(4'h1, 16'h0000);
      drive(6'h08, 3'h0, 1);
      rd(4'h0, 16'h0020);
      fork
         wr(4'h0, 16'h0000);
         drive(6'h08, 3'h0, 1);
      join
      clr(16'h0020);
      tally_and_finish;
   end
endmodule // test_tmst_status

/* sim/tmst_monitor.sv */
// Checker of the event status register bus and flag rules.
`timescale 1ns/1ps
module tmst_monitor (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wr_data,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [15:0] rd_data,
   input wire logic [15:0] event_status
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic sw;
   assign sw = wr_en && addr == 4'h0;
   rsvd_zero_a: assert property ((event_status & 16'hF00F) == 16'h0000)
      else $error("reserved status bit set");
   reset_zero_a: assert property ($fell(rst) |-> event_status == 16'h0000 && rd_data == 16'h0000)
      else $error("nonzero value after reset");
   read_idle_a: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
      else $error("read data without read");
   read_status_a: assert property (rd_en && addr == 4'h0 |=> rd_data == $past(event_status))
      else $error("status read mismatch");
   unmapped_read_a: assert property (rd_en && addr > 4'hA |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   // Flags only ever fall on a status write, so any drop is traced back one cycle.
   fall_needs_write_a: assert property (|($past(event_status) & ~event_status) |-> $past(sw))
      else $error("flag fell without write");
   ones_keep_a: assert property (sw |=> ($past(event_status & wr_data) & ~event_status) == 16'h0000)
      else $error("written one cleared flag");
   double_write_a: assert property (sw ##1 !rd_en ##1 sw |=> ($past(event_status) & ~event_status) == 16'h0000)
      else $error("unarmed write cleared flag");
endmodule // tmst_monitor
bind tmst_status tmst_monitor i_tmst_monitor (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
   .event_status);

/* verilog/tmst_defines.svh */
// Offsets, field positions and reset values of the channel 3 to 5 event status register.
`ifndef TMST_DEFINES_SVH
`define TMST_DEFINES_SVH
`define TMST_ADDR_STATUS   4'h0
`define TMST_ADDR_MODE     4'h1
`define TMST_ADDR_COUNT3   4'h2
`define TMST_ADDR_COUNT4   4'h3
`define TMST_ADDR_COUNT5   4'h4
`define TMST_ADDR_GEN5A    4'h5
`define TMST_ADDR_GEN5B    4'h6
`define TMST_ADDR_GEN4A    4'h7
`define TMST_ADDR_GEN4B    4'h8
`define TMST_ADDR_GEN4C    4'h9
`define TMST_ADDR_GEN4D    4'hA
`define TMST_BIT_CH5B      11
`define TMST_BIT_CH5A      10
`define TMST_BIT_CH4WRAP   9
`define TMST_BIT_CH4D      8
`define TMST_BIT_CH4C      7
`define TMST_BIT_CH4B      6
`define TMST_BIT_CH4A      5
`define TMST_BIT_CH3WRAP   4
`define TMST_FLAG_MASK     16'h0FF0
`define TMST_STATUS_RESET  16'h0000
`define TMST_MODE_RESET    16'h0000
`define TMST_COUNT_MAX     16'hFFFF
`define TMST_COUNT_RESET   16'h0000
`define TMST_MODE_5A       0
`define TMST_MODE_5B       2
`define TMST_MODE_4A       4
`define TMST_MODE_4B       6
`define TMST_MODE_4C       8
`define TMST_MODE_4D       10
`endif

/* verilog/tmst_event.sv */
// One general register with its capture or compare event detection.
`timescale 1ns/1ps
`include "tmst_defines.svh"
module tmst_event (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               wr_en,
   input  wire logic [15:0]        wr_data,
   input  wire logic [15:0]        counter,
   input  wire logic               capture_in,
   input  wire tmst_pkg::tmst_role_t role,
   output logic [15:0]             general,
   output logic                    event_hit
);
   typedef struct packed {
      logic [15:0] general;
   } tmst_ev_state_t;

   tmst_ev_state_t state;
   tmst_ev_state_t next_state;

   always_comb begin
      next_state = state;
      if (role == tmst_pkg::TMST_ROLE_CAPTURE && capture_in) begin
         next_state.general = counter;
      end else if (wr_en) begin
         next_state.general = wr_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Plain PWM registers raise nothing; a sync register compares like an output compare.
   always_comb begin
      unique case (role)
         tmst_pkg::TMST_ROLE_CAPTURE: event_hit = capture_in;
         tmst_pkg::TMST_ROLE_COMPARE: event_hit = (counter == state.general);
         tmst_pkg::TMST_ROLE_SYNC:    event_hit = (counter == state.general);
         tmst_pkg::TMST_ROLE_PWM:     event_hit = 1'b0;
      endcase
   end

   assign general = state.general;
endmodule // tmst_event

/* verilog/tmst_pkg.sv */
// Types shared by the channel 3 to 5 event status block.
package tmst_pkg;
   // Role of one general register.
   typedef enum logic [1:0] {
      TMST_ROLE_CAPTURE = 2'h0,
      TMST_ROLE_COMPARE = 2'h1,
      TMST_ROLE_PWM     = 2'h2,
      TMST_ROLE_SYNC    = 2'h3
   } tmst_role_t;
endpackage

/* verilog/tmst_status.sv */
// Channel 3 to 5 counters, general registers and the event status flags.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "tmst_defines.svh"
// Function
// RULE1: A flag clears only on a zero write after software read it as one.
// RULE2: All status flags read zero after reset until set.
// RULE3: Bit 11 sets on channel 5 register B capture or compare match.
// RULE4: Bit 10 sets on channel 5 register A capture or compare match.
// RULE5: In PWM mode channel 5 A, B and channel 4 A, B, C never set.
// RULE6: Bit 9 sets when channel 4 counter wraps from maximum to zero.
// RULE7: Bit 8 sets on channel 4 register D capture or compare match.
// RULE8: Bit 8 also sets on match while register D is PWM sync register.
// RULE9: Bit 7 sets on channel 4 register C capture or compare match.
// RULE10: Bit 6 sets on channel 4 register B capture or compare match.
// RULE11: Bit 5 sets on channel 4 register A capture or compare match.
// RULE12: Bit 4 sets when channel 3 counter wraps from maximum to zero.
// RULE13: Written ones are ignored; only zero clears a flag.
// RULE14: Bit 15 is reserved and always reads zero.
// RULE15: A set in the same cycle as a clearing write wins.
module tmst_status (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [15:0]      rd_data,
   input  wire logic        count3_en,
   input  wire logic        count4_en,
   input  wire logic        count5_en,
   input  wire logic        capture5a,
   input  wire logic        capture5b,
   input  wire logic        capture4a,
   input  wire logic        capture4b,
   input  wire logic        capture4c,
   input  wire logic        capture4d,
   output logic [15:0]      event_status
);
   localparam int NREG = 6;

   typedef struct packed {
      logic [15:0] status;
      logic [15:0] armed;
      logic [15:0] mode;
      logic [15:0] count3;
      logic [15:0] count4;
      logic [15:0] count5;
      logic [15:0] rd_data;
   } tmst_state_t;

   tmst_state_t state;
   tmst_state_t next_state;

   logic [NREG-1:0]     gen_wr;
   logic [NREG-1:0]     capture_in;
   logic [NREG-1:0]     hit;
   logic [15:0]         counter  [NREG];
   logic [15:0]         gen_val  [NREG];
   tmst_pkg::tmst_role_t role   [NREG];
   logic [15:0]         set_mask;
   logic [15:0]         clr_mask;
   logic                status_wr;
   logic                status_rd;
   logic                mode_wr;
   logic                count3_wr;
   logic                count4_wr;
   logic                count5_wr;
   logic                wrap3;
   logic                wrap4;

   function automatic logic wraps(input logic en, input logic [15:0] cnt);
      return en && (cnt == `TMST_COUNT_MAX);
   endfunction

   function automatic logic [15:0] step(input logic en, input logic [15:0] cnt);
      return en ? 16'(cnt + 16'h0001) : cnt;
   endfunction

   // Address decode shared by every strobe of the register bus.
   function automatic logic picks(input logic strobe, input logic [3:0] a, input logic [3:0] index);
      return strobe && (a == index);
   endfunction

   // A sync code on a register that cannot synchronise behaves as plain PWM and raises nothing.
   function automatic tmst_pkg::tmst_role_t role_of(input logic [1:0] code, input logic sync_ok);
      tmst_pkg::tmst_role_t decoded;
      decoded = tmst_pkg::tmst_role_t'(code);
      if (decoded == tmst_pkg::TMST_ROLE_SYNC && !sync_ok) begin
         decoded = tmst_pkg::TMST_ROLE_PWM;
      end
      return decoded;
   endfunction

   // The event outranks the clear so that an event at the clearing write is not lost.
   function automatic logic flag_next(input logic cur, input logic raise, input logic drop);
      return raise | (cur & ~drop);
   endfunction

   // Register order: 5A, 5B, 4A, 4B, 4C, 4D; the mode register holds two role bits for each.
   assign gen_wr[0]     = picks(wr_en, addr, `TMST_ADDR_GEN5A);
   assign gen_wr[1]     = picks(wr_en, addr, `TMST_ADDR_GEN5B);
   assign gen_wr[2]     = picks(wr_en, addr, `TMST_ADDR_GEN4A);
   assign gen_wr[3]     = picks(wr_en, addr, `TMST_ADDR_GEN4B);
   assign gen_wr[4]     = picks(wr_en, addr, `TMST_ADDR_GEN4C);
   assign gen_wr[5]     = picks(wr_en, addr, `TMST_ADDR_GEN4D);
   assign status_wr     = picks(wr_en, addr, `TMST_ADDR_STATUS);
   assign status_rd     = picks(rd_en, addr, `TMST_ADDR_STATUS);
   assign mode_wr       = picks(wr_en, addr, `TMST_ADDR_MODE);
   assign count3_wr     = picks(wr_en, addr, `TMST_ADDR_COUNT3);
   assign count4_wr     = picks(wr_en, addr, `TMST_ADDR_COUNT4);
   assign count5_wr     = picks(wr_en, addr, `TMST_ADDR_COUNT5);
   assign wrap3         = wraps(count3_en, state.count3); // RULE12
   assign wrap4         = wraps(count4_en, state.count4); // RULE6
   assign capture_in[0] = capture5a;
   assign capture_in[1] = capture5b;
   assign capture_in[2] = capture4a;
   assign capture_in[3] = capture4b;
   assign capture_in[4] = capture4c;
   assign capture_in[5] = capture4d;
   assign counter[0]    = state.count5;
   assign counter[1]    = state.count5;
   assign counter[2]    = state.count4;
   assign counter[3]    = state.count4;
   assign counter[4]    = state.count4;
   assign counter[5]    = state.count4;

   // Only register D of channel 4 may serve as a sync register.
   assign role[0]       = role_of(state.mode[`TMST_MODE_5A +: 2], 1'b0); // RULE5
   assign role[1]       = role_of(state.mode[`TMST_MODE_5B +: 2], 1'b0); // RULE5
   assign role[2]       = role_of(state.mode[`TMST_MODE_4A +: 2], 1'b0); // RULE5
   assign role[3]       = role_of(state.mode[`TMST_MODE_4B +: 2], 1'b0); // RULE5
   assign role[4]       = role_of(state.mode[`TMST_MODE_4C +: 2], 1'b0); // RULE5
   assign role[5]       = role_of(state.mode[`TMST_MODE_4D +: 2], 1'b1); // RULE8

   tmst_event i_tmst_event_5a (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[0]),
      .wr_data    (wr_data),
      .counter    (counter[0]),
      .capture_in (capture_in[0]),
      .role       (role[0]),
      .general    (gen_val[0]),
      .event_hit  (hit[0])
   );

   tmst_event i_tmst_event_5b (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[1]),
      .wr_data    (wr_data),
      .counter    (counter[1]),
      .capture_in (capture_in[1]),
      .role       (role[1]),
      .general    (gen_val[1]),
      .event_hit  (hit[1])
   );

   tmst_event i_tmst_event_4a (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[2]),
      .wr_data    (wr_data),
      .counter    (counter[2]),
      .capture_in (capture_in[2]),
      .role       (role[2]),
      .general    (gen_val[2]),
      .event_hit  (hit[2])
   );

   tmst_event i_tmst_event_4b (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[3]),
      .wr_data    (wr_data),
      .counter    (counter[3]),
      .capture_in (capture_in[3]),
      .role       (role[3]),
      .general    (gen_val[3]),
      .event_hit  (hit[3])
   );

   tmst_event i_tmst_event_4c (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[4]),
      .wr_data    (wr_data),
      .counter    (counter[4]),
      .capture_in (capture_in[4]),
      .role       (role[4]),
      .general    (gen_val[4]),
      .event_hit  (hit[4])
   );

   tmst_event i_tmst_event_4d (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_en      (gen_wr[5]),
      .wr_data    (wr_data),
      .counter    (counter[5]),
      .capture_in (capture_in[5]),
      .role       (role[5]),
      .general    (gen_val[5]),
      .event_hit  (hit[5])
   );

   always_comb begin
      set_mask = 16'h0000;
      set_mask[`TMST_BIT_CH5A]    = hit[0]; // RULE4
      set_mask[`TMST_BIT_CH5B]    = hit[1]; // RULE3
      set_mask[`TMST_BIT_CH4A]    = hit[2]; // RULE11
      set_mask[`TMST_BIT_CH4B]    = hit[3]; // RULE10
      set_mask[`TMST_BIT_CH4C]    = hit[4]; // RULE9
      set_mask[`TMST_BIT_CH4D]    = hit[5]; // RULE7 RULE8
      set_mask[`TMST_BIT_CH4WRAP] = wrap4; // RULE6
      set_mask[`TMST_BIT_CH3WRAP] = wrap3; // RULE12
   end

   // A flag clears only where it was seen as one and a zero is now written there.
   assign clr_mask = status_wr
                     ? (state.armed & ~wr_data & `TMST_FLAG_MASK) : 16'h0000; // RULE1 RULE13

   always_comb begin
      next_state = state;
      next_state.count3 = step(count3_en, state.count3);
      next_state.count4 = step(count4_en, state.count4);
      next_state.count5 = step(count5_en, state.count5);
      // Every bit outside the flag field, reserved bit 15 included, stays zero.
      next_state.status = 16'h0000; // RULE14
      next_state.status[`TMST_BIT_CH5B]    = flag_next(state.status[`TMST_BIT_CH5B],
                                                        set_mask[`TMST_BIT_CH5B],
                                                        clr_mask[`TMST_BIT_CH5B]); // RULE15
      next_state.status[`TMST_BIT_CH5A]    = flag_next(state.status[`TMST_BIT_CH5A],
                                                        set_mask[`TMST_BIT_CH5A],
                                                        clr_mask[`TMST_BIT_CH5A]); // RULE15
      next_state.status[`TMST_BIT_CH4WRAP] = flag_next(state.status[`TMST_BIT_CH4WRAP],
                                                        set_mask[`TMST_BIT_CH4WRAP],
                                                        clr_mask[`TMST_BIT_CH4WRAP]); // RULE15
      next_state.status[`TMST_BIT_CH4D]    = flag_next(state.status[`TMST_BIT_CH4D],
                                                        set_mask[`TMST_BIT_CH4D],
                                                        clr_mask[`TMST_BIT_CH4D]); // RULE15
      next_state.status[`TMST_BIT_CH4C]    = flag_next(state.status[`TMST_BIT_CH4C],
                                                        set_mask[`TMST_BIT_CH4C],
                                                        clr_mask[`TMST_BIT_CH4C]); // RULE15
      next_state.status[`TMST_BIT_CH4B]    = flag_next(state.status[`TMST_BIT_CH4B],
                                                        set_mask[`TMST_BIT_CH4B],
                                                        clr_mask[`TMST_BIT_CH4B]); // RULE15
      next_state.status[`TMST_BIT_CH4A]    = flag_next(state.status[`TMST_BIT_CH4A],
                                                        set_mask[`TMST_BIT_CH4A],
                                                        clr_mask[`TMST_BIT_CH4A]); // RULE15
      next_state.status[`TMST_BIT_CH3WRAP] = flag_next(state.status[`TMST_BIT_CH3WRAP],
                                                        set_mask[`TMST_BIT_CH3WRAP],
                                                        clr_mask[`TMST_BIT_CH3WRAP]); // RULE15
      if (status_wr) begin
         next_state.armed = 16'h0000;
      end
      if (status_rd) begin
         next_state.armed = state.status; // RULE1
      end
      // A software write to a counter wins over its step in the same cycle.
      if (mode_wr) begin
         next_state.mode = wr_data;
      end
      if (count3_wr) begin
         next_state.count3 = wr_data;
      end
      if (count4_wr) begin
         next_state.count4 = wr_data;
      end
      if (count5_wr) begin
         next_state.count5 = wr_data;
      end
      next_state.rd_data = 16'h0000;
      if (rd_en) begin
         unique case (addr)
            `TMST_ADDR_STATUS: next_state.rd_data = state.status;
            `TMST_ADDR_MODE:   next_state.rd_data = state.mode;
            `TMST_ADDR_COUNT3: next_state.rd_data = state.count3;
            `TMST_ADDR_COUNT4: next_state.rd_data = state.count4;
            `TMST_ADDR_COUNT5: next_state.rd_data = state.count5;
            `TMST_ADDR_GEN5A:  next_state.rd_data = gen_val[0];
            `TMST_ADDR_GEN5B:  next_state.rd_data = gen_val[1];
            `TMST_ADDR_GEN4A:  next_state.rd_data = gen_val[2];
            `TMST_ADDR_GEN4B:  next_state.rd_data = gen_val[3];
            `TMST_ADDR_GEN4C:  next_state.rd_data = gen_val[4];
            `TMST_ADDR_GEN4D:  next_state.rd_data = gen_val[5];
            default:           next_state.rd_data = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state.status  <= `TMST_STATUS_RESET; // RULE2
         state.armed   <= 16'h0000;
         state.rd_data <= 16'h0000;
         state.mode    <= `TMST_MODE_RESET;
         state.count3  <= `TMST_COUNT_RESET;
         state.count4  <= `TMST_COUNT_RESET;
         state.count5  <= `TMST_COUNT_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign rd_data      = state.rd_data;
   assign event_status = state.status;
endmodule // tmst_status
